// >>> design/tlc_pkg.sv
/*
  Shared constants, bus carriers and state record for the tape record
  LRC/CRC checker and failing-track locator.
  Assumes a single 200 MHz clock and an AXI4-Lite master on the same clock.
*/
`default_nettype none
package tlc_pkg;
  localparam int TLC_W = 9;
  localparam int TLC_LAST_IDX = 8;
  localparam int TLC_CPL_LO = 3;
  localparam int TLC_CPL_HI = 6;
  localparam logic [8:0] TLC_CW_GOOD = 9'h1D7;
  localparam logic [8:0] TLC_EP_GOOD = 9'h000;
  localparam logic [8:0] TLC_CMP_INV = 9'h1AF;
  localparam logic [8:0] TLC_ZERO9 = 9'h000;

  localparam int TLC_AW = 8;
  localparam logic [7:0] TLC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TLC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] TLC_ADDR_ACC = 8'h08;
  localparam logic [7:0] TLC_ADDR_CW = 8'h0C;
  localparam logic [7:0] TLC_ADDR_TRACK = 8'h10;
  localparam logic [1:0] TLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TLC_RESP_SLVERR = 2'h2;

  localparam int TLC_CTRL_WRITE = 0;
  localparam int TLC_CTRL_REV = 1;
  localparam int TLC_ST_ZERO = 0;
  localparam int TLC_ST_DERR = 1;
  localparam int TLC_ST_UNCORR = 2;
  localparam int TLC_ST_FOUND = 3;
  localparam int TLC_ST_ARM = 4;
  localparam int TLC_ST_WRONG = 5;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tlc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tlc_axi_rsp_t;

  typedef struct packed {
    logic buffer_load_phase;
    logic buffer_unload_phase;
    logic late_timing_strobe;
    logic early_timing_strobe;
    logic data_active;
    logic checkword_write_strobe;
    logic lrc_check_strobe;
    logic record_body;
    logic lrc_accumulate_enable;
    logic check_window;
    logic read_phase_one;
    logic read_phase_two;
    logic write_clear_window;
    logic buffer_nonempty;
    logic finish_flag;
  } tlc_strobe_t;

  typedef struct packed {
    logic [8:0] acc;
    logic [8:0] cw;
    logic [8:0] track;
    logic xor_ph;
    logic mis_sync;
    logic step_dly;
    logic arm;
    logic latch;
    logic data_err;
    logic cw_written;
    logic rp1_dly;
    logic wr_mode;
    logic rev_mode;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tlc_state_t;

  localparam tlc_state_t TLC_STATE_RST = '0;
endpackage
`default_nettype wire

// >>> design/tlc_locator.sv
/*
  Tape record check block: nine-stage parity accumulator with LRC zero
  test, nine-stage checkword register, and the marker walk that finds a
  single failing track. Registers over AXI4-Lite.
  Assumes all strobes come from logic on clk_i; the window and phase inputs such as check_window are held for several cycles.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
// How it works
// - Reads feed accumulator from read lines, plus marker
// - Writes feed accumulator from buffer data
// - Accumulator strobe: buffer phase-late, failure, search step
// - Accumulator clears on reset, or in write-clear window with buffer empty or finish flag
// - Enabled accumulation XORs input into each stage
// - Zero-detect is AND of all stages clear
// - Failure pulses only at check with nonzero
// - Failure sets data-error flag, clocks accumulator
// - Clocking with accumulation disabled clears all stages, except on a search step
// - Good checkword 111010111, error pattern all zero
// - First search step loads marker into parity stage
// - Steps need sync mismatch, phase two, marker short
// - Compare checkword to pattern, bits 4,6 uninverted
// - Each later mismatch step shifts accumulator and checkword
// - On match, marker position names failing track
// - Marker at last stage arms multi-track latch
// - Checkword input: forward lines or reverse read lines
// - Shift flag true XORs, false shifts checkword
// - Forward select forward; reverse select reverse reads
// - Checkword strobe: data, checkword write, nonzero step
// - Shift rotates last into first, complements 3-6 when last is set
// - Checkword register cleared by global reset
`timescale 1ns/100ps
`default_nettype none
module tlc_locator
  import tlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire tlc_axi_req_t axi_req_i,
  output tlc_axi_rsp_t axi_rsp_o,
  input wire tlc_strobe_t strb_i,
  input wire logic [8:0] read_char_lines_i,
  input wire logic [8:0] forward_data_lines_i,
  input wire logic [8:0] buffer_data_i,
  input wire logic [8:0] error_pattern_reg_i,
  output logic lrc_zero_detect_o,
  output logic data_error_o,
  output logic uncorrectable_read_error_o,
  output logic track_found_o,
  output logic [8:0] failing_track_o
);

  // Checkword shift with feedback complement of middle stages
  function automatic logic [8:0] cw_shift(input logic [8:0] c);
    logic [8:0] r;
    r = {c[7:0], c[TLC_LAST_IDX]};
    for (int i = TLC_CPL_LO; i <= TLC_CPL_HI; i++) begin
      r[i] = c[TLC_LAST_IDX] ? ~c[i-1] : c[i-1];
    end
    return r;
  endfunction

  // Write-channel byte merge
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  tlc_state_t st_ff;
  tlc_state_t nxt_st;

  logic lrc_zero;
  logic cw_good;
  logic cw_wrong_window;
  logic cmp_match;
  logic lrc_fail_pulse;
  logic track_search_step;
  logic acc_strobe;
  logic acc_clear;
  logic cw_strobe;
  logic cw_xor_mode;
  logic forward_path_select;
  logic reverse_path_select;
  logic multi_track_arm;
  logic rp1_fall;
  logic [8:0] acc_in;
  logic [8:0] acc_xor_w;
  logic [8:0] acc_shl_w;
  logic [8:0] cw_in;
  logic [8:0] cw_shift_w;
  logic [8:0] cw_xor_w;
  logic [31:0] status_w;
  logic do_write;
  logic [31:0] wr_merged;

  always_comb begin
    lrc_zero = (st_ff.acc == TLC_ZERO9);
    cw_good = (st_ff.cw == TLC_CW_GOOD) &&
              (error_pattern_reg_i == TLC_EP_GOOD);
    cw_wrong_window = strb_i.check_window && !cw_good;
    cmp_match = (st_ff.cw == (error_pattern_reg_i ^ TLC_CMP_INV));
    // Failure masked through the record body
    lrc_fail_pulse = strb_i.lrc_check_strobe && !strb_i.record_body &&
                     !lrc_zero;
    // Steps spaced one idle cycle apart so the compare settles
    track_search_step = cw_wrong_window && st_ff.mis_sync &&
                        strb_i.read_phase_two &&
                        !st_ff.acc[TLC_LAST_IDX] &&
                        (!cmp_match || lrc_zero) &&
                        !st_ff.step_dly;
    acc_in = st_ff.wr_mode ? buffer_data_i
                           : read_char_lines_i;
    acc_xor_w = st_ff.acc ^ acc_in;
    // Marker enters the parity stage while the accumulator is clear
    acc_shl_w = {st_ff.acc[7:0],
                 lrc_zero && cw_wrong_window};
    acc_strobe = ((strb_i.buffer_load_phase ||
                   strb_i.buffer_unload_phase) &&
                  strb_i.late_timing_strobe) ||
                 lrc_fail_pulse || track_search_step;
    acc_clear = strb_i.write_clear_window &&
                (!strb_i.buffer_nonempty ||
                 strb_i.finish_flag);
    forward_path_select = !st_ff.rev_mode || st_ff.wr_mode;
    reverse_path_select = !forward_path_select;
    cw_in = reverse_path_select ? read_char_lines_i
                                : forward_data_lines_i;
    cw_shift_w = cw_shift(st_ff.cw);
    cw_xor_w = st_ff.cw ^ cw_in;
    cw_strobe = ((strb_i.early_timing_strobe ||
                  strb_i.late_timing_strobe) &&
                 strb_i.data_active && !st_ff.cw_written) ||
                strb_i.checkword_write_strobe ||
                (track_search_step && !lrc_zero);
    cw_xor_mode = st_ff.xor_ph && !track_search_step;
    multi_track_arm = cw_wrong_window && st_ff.acc[TLC_LAST_IDX] &&
                      !cmp_match;
    rp1_fall = st_ff.rp1_dly && !strb_i.read_phase_one;
    status_w = '0;
    status_w[TLC_ST_ZERO] = lrc_zero;
    status_w[TLC_ST_DERR] = st_ff.data_err;
    status_w[TLC_ST_UNCORR] = st_ff.latch;
    status_w[TLC_ST_FOUND] = track_found_o;
    status_w[TLC_ST_ARM] = st_ff.arm;
    status_w[TLC_ST_WRONG] = cw_wrong_window;
    do_write = st_ff.aw_full && st_ff.w_full && !st_ff.bvalid;
    wr_merged = merge(32'h0000_0000, st_ff.wdata, st_ff.wstrb);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rp1_dly = strb_i.read_phase_one;
    nxt_st.mis_sync = cw_wrong_window;
    nxt_st.step_dly = track_search_step;

    // Parity accumulator
    if (acc_clear) begin
      nxt_st.acc = TLC_ZERO9;
    end else if (acc_strobe) begin
      if (strb_i.lrc_accumulate_enable) begin
        nxt_st.acc = acc_xor_w;
      end else if (track_search_step) begin
        nxt_st.acc = acc_shl_w;
      end else begin
        nxt_st.acc = TLC_ZERO9;
      end
    end

    // Checkword register
    if (cw_strobe) begin
      nxt_st.cw = cw_xor_mode ? cw_xor_w : cw_shift_w;
      if (!track_search_step) begin
        nxt_st.xor_ph = !st_ff.xor_ph;
      end
    end
    if (strb_i.checkword_write_strobe) begin
      nxt_st.cw_written = 1'b1;
    end else if (strb_i.write_clear_window) begin
      nxt_st.cw_written = 1'b0;
    end

    // Track found: marker position captured on match
    if (cw_wrong_window && cmp_match && !lrc_zero) begin
      nxt_st.track = st_ff.acc;
    end

    // Multi-track latch
    if (multi_track_arm) begin
      nxt_st.arm = 1'b1;
    end else if (!strb_i.read_phase_one) begin
      nxt_st.arm = 1'b0;
    end

    // Register writes; hardware set wins over software clear
    if (do_write) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = TLC_RESP_OKAY;
      if (st_ff.aw_addr == TLC_ADDR_CTRL) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.wr_mode = st_ff.wdata[TLC_CTRL_WRITE];
          nxt_st.rev_mode = st_ff.wdata[TLC_CTRL_REV];
        end
      end else if (st_ff.aw_addr == TLC_ADDR_STATUS) begin
        if (wr_merged[TLC_ST_DERR]) begin
          nxt_st.data_err = 1'b0;
        end
        if (wr_merged[TLC_ST_UNCORR]) begin
          nxt_st.latch = 1'b0;
        end
      end else if (st_ff.aw_addr == TLC_ADDR_ACC ||
                   st_ff.aw_addr == TLC_ADDR_CW ||
                   st_ff.aw_addr == TLC_ADDR_TRACK) begin
        nxt_st.bresp = TLC_RESP_OKAY;
      end else begin
        nxt_st.bresp = TLC_RESP_SLVERR;
      end
    end
    if (lrc_fail_pulse) begin
      nxt_st.data_err = 1'b1;
    end
    if (rp1_fall && st_ff.arm) begin
      nxt_st.latch = 1'b1;
    end

    // Write address and data captured in either order
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.wdata = axi_req_i.wdata;
      nxt_st.wstrb = axi_req_i.wstrb;
    end
    if (st_ff.bvalid && axi_req_i.bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Read channel
    if (st_ff.rvalid && axi_req_i.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && axi_rsp_o.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = TLC_RESP_OKAY;
      nxt_st.rdata = '0;
      if (axi_req_i.araddr == TLC_ADDR_CTRL) begin
        nxt_st.rdata[TLC_CTRL_WRITE] = st_ff.wr_mode;
        nxt_st.rdata[TLC_CTRL_REV] = st_ff.rev_mode;
      end else if (axi_req_i.araddr == TLC_ADDR_STATUS) begin
        nxt_st.rdata = status_w;
      end else if (axi_req_i.araddr == TLC_ADDR_ACC) begin
        nxt_st.rdata[8:0] = st_ff.acc;
      end else if (axi_req_i.araddr == TLC_ADDR_CW) begin
        nxt_st.rdata[8:0] = st_ff.cw;
      end else if (axi_req_i.araddr == TLC_ADDR_TRACK) begin
        nxt_st.rdata[8:0] = st_ff.track;
      end else begin
        nxt_st.rresp = TLC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= TLC_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    axi_rsp_o.awready = !st_ff.aw_full;
    axi_rsp_o.wready = !st_ff.w_full;
    axi_rsp_o.bvalid = st_ff.bvalid;
    axi_rsp_o.bresp = st_ff.bresp;
    axi_rsp_o.arready = !st_ff.rvalid;
    axi_rsp_o.rvalid = st_ff.rvalid;
    axi_rsp_o.rdata = st_ff.rdata;
    axi_rsp_o.rresp = st_ff.rresp;
    lrc_zero_detect_o = lrc_zero;
    data_error_o = st_ff.data_err;
    uncorrectable_read_error_o = st_ff.latch;
    failing_track_o = st_ff.track;
    track_found_o = (st_ff.track != TLC_ZERO9);
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_clear_window;
    acc_clear |=> st_ff.acc == TLC_ZERO9;
  endproperty
  a_clear_window: assert property (p_clear_window)
    else $error("accumulator not cleared by write-clear window");

  property p_acc_xor;
    acc_strobe && strb_i.lrc_accumulate_enable && !acc_clear
      |=> st_ff.acc == $past(acc_xor_w);
  endproperty
  a_acc_xor: assert property (p_acc_xor)
    else $error("accumulator did not take exclusive-OR of input");

  property p_fail_cause;
    lrc_fail_pulse |-> !lrc_zero && strb_i.lrc_check_strobe &&
                       !strb_i.record_body;
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("LRC failure pulse without cause");

  property p_fail_sets_error;
    lrc_fail_pulse |=> data_error_o;
  endproperty
  a_fail_sets_error: assert property (p_fail_sets_error)
    else $error("data-error flag not set after LRC failure");

  property p_disabled_clears;
    lrc_fail_pulse && !strb_i.lrc_accumulate_enable
      |=> st_ff.acc == TLC_ZERO9;
  endproperty
  a_disabled_clears: assert property (p_disabled_clears)
    else $error("accumulator not cleared when clocked disabled");

  property p_first_marker;
    track_search_step && lrc_zero && !acc_clear &&
      !strb_i.lrc_accumulate_enable |=> st_ff.acc[0] && $onehot(st_ff.acc);
  endproperty
  a_first_marker: assert property (p_first_marker)
    else $error("marker not placed in parity stage");

  property p_step_qual;
    track_search_step |-> strb_i.read_phase_two &&
      !st_ff.acc[TLC_LAST_IDX] && $past(cw_wrong_window)
      ##1 !track_search_step;
  endproperty
  a_step_qual: assert property (p_step_qual)
    else $error("search step without qualification");

  property p_cw_shift;
    cw_strobe && !cw_xor_mode |=> st_ff.cw == $past(cw_shift_w);
  endproperty
  a_cw_shift: assert property (p_cw_shift)
    else $error("checkword register did not shift");

  property p_latch;
    rp1_fall && st_ff.arm |=> uncorrectable_read_error_o [*2];
  endproperty
  a_latch: assert property (p_latch)
    else $error("multi-track latch not captured");

  c_fail: cover property (lrc_fail_pulse);
  c_step: cover property (track_search_step && !lrc_zero);
  c_found: cover property (!track_found_o ##1 track_found_o);
  c_uncorr: cover property ($rose(uncorrectable_read_error_o));

endmodule // tlc_locator
`default_nettype wire

// >>> testbench/tlc_tape_model.sv
/*
  Far-side model: tape read register and buffer handing one
  character to the checker with its early and late timing strobes.
  Assumes go_i is a one-cycle request from the bench on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module tlc_tape_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic go_i,
  input wire logic [1:0] mode_i,
  input wire logic [8:0] char_i,
  output logic busy_o,
  output logic load_o,
  output logic unload_o,
  output logic early_o,
  output logic late_o,
  output logic [8:0] rc_o,
  output logic [8:0] fw_o,
  output logic [8:0] buf_o
);
  logic [1:0] ph_ff;
  logic [8:0] ch_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_ff <= 2'h0;
      ch_ff <= 9'h000;
    end else if (go_i) begin
      ph_ff <= 2'h1;
      ch_ff <= char_i;
    end else if (ph_ff != 2'h0) begin
      ph_ff <= ph_ff + 2'h1;
    end
  end
  // Mode 0 forward read, 1 write, 2 reverse read
  assign busy_o = (ph_ff != 2'h0);
  assign early_o = (ph_ff == 2'h1);
  assign late_o = (ph_ff == 2'h2);
  assign load_o = busy_o && (mode_i != 2'h1);
  assign unload_o = busy_o && (mode_i == 2'h1);
  // Unused lines show the inverse of the last character
  assign rc_o = (busy_o && mode_i != 2'h1) ? ch_ff : ~ch_ff;
  assign fw_o = (busy_o && mode_i != 2'h2) ? ch_ff : ~ch_ff;
  assign buf_o = (busy_o && mode_i == 2'h1) ? ch_ff : ~ch_ff;
endmodule // tlc_tape_model
`default_nettype wire

// >>> testbench/tlc_locator_tb_top.sv
/*
  Self-checking bench for the LRC/CRC track error locator.
  Assumes the tape model file and the design package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tlc_locator_tb_top
  import tlc_pkg::*;
;
  logic clk_i, arst_n_i, go, zd, de, ue, tf;
  logic pm_busy, pm_load, pm_unload, pm_early, pm_late;
  logic [1:0] mode;
  logic [8:0] ch, ep, ft, rc, fw, bf, macc, mcw, scw;
  tlc_axi_req_t req;
  tlc_axi_rsp_t rsp;
  tlc_strobe_t tbs, strb;
  int bad_count, samples_checked;

  always_comb begin
    strb = tbs;
    strb.buffer_load_phase = pm_load;
    strb.buffer_unload_phase = pm_unload;
    strb.early_timing_strobe = pm_early;
    strb.late_timing_strobe = pm_late;
  end

  tlc_locator dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .axi_req_i(req),
    .axi_rsp_o(rsp), .strb_i(strb), .read_char_lines_i(rc),
    .forward_data_lines_i(fw), .buffer_data_i(bf),
    .error_pattern_reg_i(ep), .lrc_zero_detect_o(zd), .data_error_o(de),
    .uncorrectable_read_error_o(ue), .track_found_o(tf),
    .failing_track_o(ft));
  tlc_tape_model pm_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .go_i(go),
    .mode_i(mode), .char_i(ch), .busy_o(pm_busy), .load_o(pm_load),
    .unload_o(pm_unload), .early_o(pm_early), .late_o(pm_late),
    .rc_o(rc), .fw_o(fw), .buf_o(bf));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic test_done;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [8:0] sh(input logic [8:0] c);
    logic [8:0] r;
    r = {c[7:0], c[8]};
    if (c[8]) begin
      for (int i = TLC_CPL_LO; i <= TLC_CPL_HI; i++) r[i] = ~c[i-1];
    end
    return r;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_i);
      if (!ad && rsp.awready) begin
        ad = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!wd && rsp.wready) begin
        wd = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    req.bready <= 1'b1;
    do begin @(posedge clk_i); end while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk($sformatf("bresp %h", a), {30'h0, rsp.bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin @(posedge clk_i); end while (!rsp.arready);
    req.arvalid <= 1'b0;
    req.rready <= 1'b1;
    do begin @(posedge clk_i); end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk($sformatf("rdata %h", a), rsp.rdata, e);
    chk($sformatf("rresp %h", a), {30'h0, rsp.rresp}, {30'h0, er});
  endtask

  task automatic rst;
    arst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    macc = 9'h000;
    mcw = 9'h000;
    @(posedge clk_i);
  endtask

  // One character: checkword shifts then XORs, accumulator XORs
  task automatic put(input logic [8:0] c);
    int n;
    n = 0;
    ch <= c;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do begin @(posedge clk_i); n++; end while (pm_busy && n < 9);
    macc = macc ^ c;
    mcw = sh(mcw) ^ c;
  endtask

  task automatic lchk(input logic body);
    tbs.record_body <= body;
    tbs.lrc_check_strobe <= 1'b1;
    @(posedge clk_i);
    tbs.lrc_check_strobe <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic win(input logic rp2);
    tbs.check_window <= 1'b1;
    tbs.read_phase_one <= 1'b1;
    tbs.read_phase_two <= rp2;
    tbs.lrc_accumulate_enable <= 1'b0;
  endtask

  task automatic srch(input logic [8:0] e);
    logic [8:0] c, t;
    int n;
    c = mcw;
    t = 9'h000;
    n = 0;
    for (int j = 0; j < 9; j++) begin
      if (t == 9'h000 && (c ^ TLC_CMP_INV) == e) t = 9'h001 << j;
      c = sh(c);
    end
    ep <= e;
    win(1'b0);
    repeat (6) @(posedge clk_i);
    chk("no step in phase one", {31'h0, zd}, 32'h1);
    tbs.read_phase_two <= 1'b1;
    do begin @(posedge clk_i); n++; end while (!tf && n < 40);
    chk("track", {23'h0, ft}, {23'h0, t});
    chk("found", {31'h0, tf}, {31'h0, t != 9'h000});
    rd(TLC_ADDR_TRACK, {23'h0, t}, TLC_RESP_OKAY);
    rd(TLC_ADDR_STATUS, (t == 9'h000) ? 32'h30 : 32'h28,
       TLC_RESP_OKAY);
    tbs.read_phase_one <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("uncorrectable", {31'h0, ue}, {31'h0, t == 9'h000});
    tbs.check_window <= 1'b0;
    tbs.read_phase_two <= 1'b0;
  endtask

  task automatic frec;
    rst();
    mode <= 2'h0;
    tbs.lrc_accumulate_enable <= 1'b1;
    put(9'h0B6);
    put(9'h14D);
    put(9'h0B6 ^ 9'h14D);
    lchk(1'b0);
    chk("good lrc", {30'h0, de, zd}, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done();
  end

  initial begin
    arst_n_i = 1'b0;
    req = '0;
    tbs = '0;
    tbs.data_active = 1'b1;
    tbs.lrc_accumulate_enable = 1'b1;
    go = 1'b0;
    mode = 2'h0;
    ch = 9'h000;
    ep = 9'h000;
    bad_count = 0;
    samples_checked = 0;
    rst();
    rd(TLC_ADDR_CTRL, 32'h0, TLC_RESP_OKAY);
    rd(TLC_ADDR_STATUS, 32'h1, TLC_RESP_OKAY);
    rd(TLC_ADDR_CW, 32'h0, TLC_RESP_OKAY);
    wr(8'h20, 32'h1, TLC_RESP_SLVERR);
    rd(8'h20, 32'h0, TLC_RESP_SLVERR);
    wr(TLC_ADDR_ACC, 32'h1FF, TLC_RESP_OKAY);
    rd(TLC_ADDR_ACC, 32'h0, TLC_RESP_OKAY);
    // Reverse read, body mask, then LRC failure
    wr(TLC_ADDR_CTRL, 32'h2, TLC_RESP_OKAY);
    mode <= 2'h2;
    put(9'h1A5);
    put(9'h0C3);
    rd(TLC_ADDR_ACC, {23'h0, macc}, TLC_RESP_OKAY);
    rd(TLC_ADDR_CW, {23'h0, mcw}, TLC_RESP_OKAY);
    lchk(1'b1);
    chk("masked", {31'h0, de}, 32'h0);
    tbs.lrc_accumulate_enable <= 1'b0;
    lchk(1'b0);
    chk("fail", {30'h0, de, zd}, 32'h3);
    tbs.lrc_accumulate_enable <= 1'b1;
    rd(TLC_ADDR_STATUS, 32'h3, TLC_RESP_OKAY);
    wr(TLC_ADDR_STATUS, 32'h2, TLC_RESP_OKAY);
    rd(TLC_ADDR_STATUS, 32'h1, TLC_RESP_OKAY);
    // Write path and clear window
    rst();
    wr(TLC_ADDR_CTRL, 32'h1, TLC_RESP_OKAY);
    mode <= 2'h1;
    put(9'h155);
    put(9'h0F0);
    rd(TLC_ADDR_ACC, {23'h0, macc}, TLC_RESP_OKAY);
    rd(TLC_ADDR_CW, {23'h0, mcw}, TLC_RESP_OKAY);
    // Checkword write shifts once, then data strobes are ignored
    tbs.checkword_write_strobe <= 1'b1;
    @(posedge clk_i);
    tbs.checkword_write_strobe <= 1'b0;
    scw = sh(mcw);
    put(9'h033);
    rd(TLC_ADDR_CW, {23'h0, scw}, TLC_RESP_OKAY);
    tbs.write_clear_window <= 1'b1;
    tbs.buffer_nonempty <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("no clear", {31'h0, zd}, 32'h0);
    tbs.finish_flag <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("clear", {31'h0, zd}, 32'h1);
    tbs.write_clear_window <= 1'b0;
    tbs.finish_flag <= 1'b0;
    // Good checkword: no search steps
    rst();
    mode <= 2'h0;
    put(TLC_CW_GOOD);
    ep <= TLC_EP_GOOD;
    win(1'b1);
    repeat (20) @(posedge clk_i);
    rd(TLC_ADDR_ACC, {23'h0, TLC_CW_GOOD}, TLC_RESP_OKAY);
    rd(TLC_ADDR_STATUS, 32'h0, TLC_RESP_OKAY);
    tbs.check_window <= 1'b0;
    tbs.read_phase_one <= 1'b0;
    tbs.read_phase_two <= 1'b0;
    // Single failing track, then no match at all
    frec();
    srch(sh(sh(mcw)) ^ TLC_CMP_INV);
    frec();
    srch(9'h000);
    test_done();
  end
endmodule // tlc_locator_tb_top
`default_nettype wire
